// File: alstat_consts.svh
`ifndef ALSTAT_CONSTS_SVH
`define ALSTAT_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register placement within the bus master I/O window
`define ALSTAT_OFS_W 8
`define ALSTAT_GLOBAL_STATUS_OFS 8'h30
`define ALSTAT_GLOBAL_STATUS_RST 32'h0030_0000
`define ALSTAT_DWORD_BE 4'hf

////////////////////////////////////////////////////////////////////////////////
// Field positions of global_status
`define ALSTAT_BIT_SIX_CH 21
`define ALSTAT_BIT_FOUR_CH 20
`define ALSTAT_BIT_MODEM_SEMA 17
`define ALSTAT_BIT_AUDIO_SEMA 16
`define ALSTAT_BIT_READ_TIMEOUT 15
`define ALSTAT_BIT_SLOT_HI 14
`define ALSTAT_BIT_SLOT_LO 12
`define ALSTAT_BIT_SEC_RESUME 11
`define ALSTAT_BIT_PRI_RESUME 10
`define ALSTAT_BIT_SEC_READY 9
`define ALSTAT_BIT_PRI_READY 8
`define ALSTAT_BIT_MIC_IN 7
`define ALSTAT_BIT_PCM_OUT 6
`define ALSTAT_BIT_PCM_IN 5
`define ALSTAT_BIT_MODEM_OUT 2
`define ALSTAT_BIT_MODEM_IN 1
`define ALSTAT_BIT_GPIO_CHANGE 0

////////////////////////////////////////////////////////////////////////////////
// Crossing depth and number of codec inputs
`define ALSTAT_SYNC_STAGES 2
`define ALSTAT_NUM_CODECS 2
`define ALSTAT_XING_W 6

`endif

// File: alstat_pkg.sv
package alstat_pkg;

    // Low four bits of a received slot 12
    typedef struct packed {
        logic [2:0] mirror;
        logic gpio_change;
    } alstat_slot_t;

    // Per-channel bus master interrupt lines
    typedef struct packed {
        logic mic_in;
        logic pcm_out;
        logic pcm_in;
        logic modem_out;
        logic modem_in;
    } alstat_chan_irq_t;

    // One I/O access from the host side
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } alstat_io_req_t;

endpackage : alstat_pkg

// File: alstat_link_front.sv
`include "alstat_consts.svh"

module alstat_link_front
    import alstat_pkg::*;
#(
    parameter int NUM_CODECS = `ALSTAT_NUM_CODECS
)
(
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic slot12_valid,
    input alstat_slot_t slot12_low,
    input wire logic [NUM_CODECS-1:0] codec_ready_in,
    input wire logic [NUM_CODECS-1:0] resume_det,
    output alstat_slot_t slot_hold_r,
    output logic slot_tog_r,
    output logic gpio_tog_r,
    output logic [NUM_CODECS-1:0] ready_r,
    output logic [NUM_CODECS-1:0] resume_tog_r
);

    ////////////////////////////////////////////////////////////////////////////
    // Slot 12 capture; the hold register only moves once per frame, which
    // leaves the core side a whole frame to sample it after the toggle
    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            slot_hold_r <= '0;
            slot_tog_r <= 1'b0;
            gpio_tog_r <= 1'b0;
        end
        else if (slot12_valid)
        begin
            slot_hold_r <= slot12_low;
            slot_tog_r <= ~slot_tog_r;
            gpio_tog_r <= gpio_tog_r ^ slot12_low.gpio_change;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ready levels and resume events, one set per codec input
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CODECS; gi++)
        begin : g_codec
            always_ff @(posedge link_clk)
            begin
                if (link_rst)
                begin
                    ready_r[gi] <= 1'b0;
                    resume_tog_r[gi] <= 1'b0;
                end
                else
                begin
                    ready_r[gi] <= codec_ready_in[gi];
                    resume_tog_r[gi] <= resume_tog_r[gi] ^ resume_det[gi];
                end
            end
        end
    endgenerate

endmodule : alstat_link_front

// File: alstat_top.sv
`include "alstat_consts.svh"

module alstat_top
    import alstat_pkg::*;
#(
    parameter int SYNC_STAGES = `ALSTAT_SYNC_STAGES,
    parameter int NUM_CODECS = `ALSTAT_NUM_CODECS
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic suspend_rst,
    input alstat_io_req_t io_req,
    output logic [31:0] io_rdata_r,
    output logic io_ack_r,
    input wire logic read_timeout,
    input alstat_chan_irq_t chan_irq,
    input wire logic gpio_change_irq_enable,
    input wire logic [NUM_CODECS-1:0] resume_irq_enable,
    output logic gpio_change_irq_r,
    output logic [NUM_CODECS-1:0] resume_irq_r,
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic slot12_valid,
    input alstat_slot_t slot12_low,
    input wire logic [NUM_CODECS-1:0] codec_ready_in,
    input wire logic [NUM_CODECS-1:0] resume_det
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    generate
        if (SYNC_STAGES < 2)
        begin : g_bad_sync
            $error("alstat_top: SYNC_STAGES must be at least 2");
        end
        if (NUM_CODECS != 2)
        begin : g_bad_codecs
            $error("alstat_top: the register holds exactly two codec inputs");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Access decode, shared by the read and the write path
    function automatic logic dword_hit(
        input logic [`ALSTAT_OFS_W-1:0] addr,
        input logic [3:0] be
    );
        // Partial accesses are not served: only a full dword matches
        return (addr == `ALSTAT_GLOBAL_STATUS_OFS) && (be == `ALSTAT_DWORD_BE);
    endfunction : dword_hit

    ////////////////////////////////////////////////////////////////////////////
    // Link-side front end
    alstat_slot_t slot_hold;
    logic slot_tog;
    logic gpio_tog;
    logic [NUM_CODECS-1:0] link_ready;
    logic [NUM_CODECS-1:0] resume_tog;

    alstat_link_front #(
        .NUM_CODECS(NUM_CODECS)
    ) u_link_front (
        .link_clk(link_clk),
        .link_rst(link_rst),
        .slot12_valid(slot12_valid),
        .slot12_low(slot12_low),
        .codec_ready_in(codec_ready_in),
        .resume_det(resume_det),
        .slot_hold_r(slot_hold),
        .slot_tog_r(slot_tog),
        .gpio_tog_r(gpio_tog),
        .ready_r(link_ready),
        .resume_tog_r(resume_tog)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Crossing into core_clk: toggles for events, plain chains for levels.
    // Only the last stage is read; earlier stages feed the next stage only.
    logic [`ALSTAT_XING_W-1:0] xing_in;
    logic [SYNC_STAGES-1:0][`ALSTAT_XING_W-1:0] xing_r;
    logic [`ALSTAT_XING_W-1:0] xing_prev_r;
    logic [`ALSTAT_XING_W-1:0] xing_now;

    assign xing_in = {resume_tog, link_ready, gpio_tog, slot_tog};
    assign xing_now = xing_r[SYNC_STAGES-1];

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            xing_r <= '0;
            xing_prev_r <= '0;
        end
        else
        begin
            xing_r <= {xing_r[SYNC_STAGES-2:0], xing_in};
            xing_prev_r <= xing_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event arming after core reset. The link side may run on through a core
    // reset, so a toggle can sit at 1 while the edge detector restarts from 0;
    // events stay masked until the last stage and its copy hold real samples.
    // The price is that an event inside those few cycles is dropped.
    logic [SYNC_STAGES:0] arm_r;
    logic xing_armed;

    assign xing_armed = arm_r[SYNC_STAGES];

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            arm_r <= '0;
        end
        else
        begin
            arm_r <= {arm_r[SYNC_STAGES-1:0], 1'b1};
        end
    end

    // Edge of each toggle marks one event in the core domain
    logic slot_evt;
    logic gpio_evt;
    logic [NUM_CODECS-1:0] resume_evt;
    logic [NUM_CODECS-1:0] ready_now;

    assign slot_evt = xing_armed & (xing_now[0] ^ xing_prev_r[0]);
    assign gpio_evt = xing_armed & (xing_now[1] ^ xing_prev_r[1]);
    assign ready_now = xing_now[3:2];
    assign resume_evt = {NUM_CODECS{xing_armed}} & (xing_now[5:4] ^ xing_prev_r[5:4]);

    ////////////////////////////////////////////////////////////////////////////
    // Request qualification
    logic rd_hit;
    logic wr_hit;
    logic [31:0] clr_mask;

    assign rd_hit = io_req.rd && dword_hit(io_req.addr, io_req.be);
    assign wr_hit = io_req.wr && dword_hit(io_req.addr, io_req.be);
    // Only ones written while hitting the register clear anything
    assign clr_mask = wr_hit ? io_req.wdata : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags; an event in the cycle of its clear wins over the clear
    logic timeout_r;
    logic timeout_nxt;
    logic gpio_flag_r;
    logic gpio_flag_nxt;
    logic [NUM_CODECS-1:0] resume_r;
    logic [NUM_CODECS-1:0] resume_nxt;
    logic [NUM_CODECS-1:0] resume_clr;

    assign resume_clr = {clr_mask[`ALSTAT_BIT_SEC_RESUME], clr_mask[`ALSTAT_BIT_PRI_RESUME]};
    assign timeout_nxt = read_timeout | (timeout_r & ~clr_mask[`ALSTAT_BIT_READ_TIMEOUT]);
    assign gpio_flag_nxt = gpio_evt | (gpio_flag_r & ~clr_mask[`ALSTAT_BIT_GPIO_CHANGE]);
    assign resume_nxt = resume_evt | (resume_r & ~resume_clr);

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            timeout_r <= 1'b0;
            gpio_flag_r <= 1'b0;
            resume_r <= '0;
        end
        else
        begin
            timeout_r <= timeout_nxt;
            gpio_flag_r <= gpio_flag_nxt;
            resume_r <= resume_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slot 12 mirror, sampled when the frame toggle arrives. The hold register
    // on the link side is stable by then, so the three bits never tear.
    logic [2:0] mirror_r;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            mirror_r <= 3'h0;
        end
        else if (slot_evt)
        begin
            mirror_r <= slot_hold.mirror;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power-down semaphores live in the suspend well: of the two resets only suspend_rst
    // clears them, so a core reset leaves software's handshake intact.
    logic modem_sema_r;
    logic audio_sema_r;

    always_ff @(posedge core_clk)
    begin
        if (suspend_rst)
        begin
            modem_sema_r <= 1'b0;
            audio_sema_r <= 1'b0;
        end
        else if (wr_hit)
        begin
            modem_sema_r <= io_req.wdata[`ALSTAT_BIT_MODEM_SEMA];
            audio_sema_r <= io_req.wdata[`ALSTAT_BIT_AUDIO_SEMA];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status word assembly; every unnamed bit stays zero
    logic [31:0] status_word;

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[`ALSTAT_BIT_SIX_CH] = 1'b1;
        status_word[`ALSTAT_BIT_FOUR_CH] = 1'b1;
        status_word[`ALSTAT_BIT_MODEM_SEMA] = modem_sema_r;
        status_word[`ALSTAT_BIT_AUDIO_SEMA] = audio_sema_r;
        status_word[`ALSTAT_BIT_READ_TIMEOUT] = timeout_r;
        status_word[`ALSTAT_BIT_SLOT_HI:`ALSTAT_BIT_SLOT_LO] = mirror_r;
        status_word[`ALSTAT_BIT_SEC_RESUME] = resume_r[1];
        status_word[`ALSTAT_BIT_PRI_RESUME] = resume_r[0];
        status_word[`ALSTAT_BIT_SEC_READY] = ready_now[1];
        status_word[`ALSTAT_BIT_PRI_READY] = ready_now[0];
        // Summaries follow the channel lines directly, so they drop with them
        status_word[`ALSTAT_BIT_MIC_IN] = chan_irq.mic_in;
        status_word[`ALSTAT_BIT_PCM_OUT] = chan_irq.pcm_out;
        status_word[`ALSTAT_BIT_PCM_IN] = chan_irq.pcm_in;
        status_word[`ALSTAT_BIT_MODEM_OUT] = chan_irq.modem_out;
        status_word[`ALSTAT_BIT_MODEM_IN] = chan_irq.modem_in;
        status_word[`ALSTAT_BIT_GPIO_CHANGE] = gpio_flag_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Answer path: every access is acknowledged one cycle later; a read that
    // misses the register or is not a full dword returns zero
    logic [31:0] rdata_nxt;

    assign rdata_nxt = rd_hit ? status_word : 32'h0000_0000;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            io_ack_r <= 1'b0;
            io_rdata_r <= 32'h0000_0000;
        end
        else
        begin
            io_ack_r <= io_req.rd | io_req.wr;
            io_rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt requests: the flags set regardless of enables, the enables
    // only gate the request lines
    logic gpio_irq_nxt;
    logic [NUM_CODECS-1:0] resume_irq_nxt;

    assign gpio_irq_nxt = gpio_flag_r & gpio_change_irq_enable;
    assign resume_irq_nxt = resume_r & resume_irq_enable;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            gpio_change_irq_r <= 1'b0;
            resume_irq_r <= '0;
        end
        else
        begin
            gpio_change_irq_r <= gpio_irq_nxt;
            resume_irq_r <= resume_irq_nxt;
        end
    end

endmodule : alstat_top

// File: alstat_top_assertions.sv
module alstat_top_assertions
    import alstat_pkg::*;
#(
    parameter int NUM_CODECS = 2
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input alstat_io_req_t io_req,
    input wire logic [31:0] io_rdata_r,
    input wire logic io_ack_r,
    input wire logic read_timeout,
    input alstat_chan_irq_t chan_irq,
    input wire logic gpio_change_irq_enable,
    input wire logic [NUM_CODECS-1:0] resume_irq_enable,
    input wire logic gpio_change_irq_r,
    input wire logic [NUM_CODECS-1:0] resume_irq_r
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // Only a full dword at 30h hits; a read and write together is left out
    wire hit = io_req.addr == 8'h30 && io_req.be == 4'hf;
    wire hit_rd = hit && io_req.rd && !io_req.wr;
    wire hit_wr = hit && io_req.wr && !io_req.rd;
    wire req = io_req.rd || io_req.wr;
    wire [4:0] chan_v = chan_irq;

    ////////////////////////////////////////
    // Time-out then a read two cycles on, with no clearing write between
    sequence s_timeout;
        read_timeout ##1 !io_req.wr ##1 hit_rd;
    endsequence
    // Clearing write, then a read two cycles on, no new time-out
    sequence s_clear;
        hit_wr && io_req.wdata[15] && !read_timeout ##1 !read_timeout ##1
            (hit_rd && !read_timeout);
    endsequence

    property p_ack;
        req |=> io_ack_r;
    endproperty
    property p_idle;
        !req |=> !io_ack_r && io_rdata_r == 32'h0;
    endproperty
    property p_miss;
        io_req.rd && !hit |=> io_rdata_r == 32'h0;
    endproperty
    property p_caps;
        hit_rd |=> io_rdata_r[21:20] == 2'b11;
    endproperty
    property p_resv;
        io_ack_r |-> io_rdata_r[31:22] == 10'h0 && io_rdata_r[19:18] == 2'h0
            && io_rdata_r[4:3] == 2'h0;
    endproperty
    property p_timeout;
        s_timeout |=> io_rdata_r[15];
    endproperty
    property p_clear;
        s_clear |=> !io_rdata_r[15];
    endproperty
    property p_chan;
        hit_rd |=> io_rdata_r[7:5] == $past(chan_v[4:2])
            && io_rdata_r[2:1] == $past(chan_v[1:0]);
    endproperty
    property p_gpio_irq;
        gpio_change_irq_r |-> $past(gpio_change_irq_enable);
    endproperty
    property p_res_irq;
        (resume_irq_r & ~$past(resume_irq_enable)) == 2'h0;
    endproperty

    a_ack: assert property (p_ack) else $error("access not acked");
    a_idle: assert property (p_idle) else $error("ack without access");
    a_miss: assert property (p_miss) else $error("miss read not zero");
    a_caps: assert property (p_caps) else $error("capability bits low");
    a_resv: assert property (p_resv) else $error("reserved bit set");
    a_timeout: assert property (p_timeout) else $error("timeout flag lost");
    a_clear: assert property (p_clear) else $error("timeout flag kept");
    a_chan: assert property (p_chan) else $error("channel summary wrong");
    a_gpio_irq: assert property (p_gpio_irq) else $error("gpio irq masked");
    a_res_irq: assert property (p_res_irq) else $error("resume irq masked");
endmodule : alstat_top_assertions

bind alstat_top alstat_top_assertions #(.NUM_CODECS(NUM_CODECS)) u_chk (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .io_req(io_req),
    .io_rdata_r(io_rdata_r),
    .io_ack_r(io_ack_r),
    .read_timeout(read_timeout),
    .chan_irq(chan_irq),
    .gpio_change_irq_enable(gpio_change_irq_enable),
    .resume_irq_enable(resume_irq_enable),
    .gpio_change_irq_r(gpio_change_irq_r),
    .resume_irq_r(resume_irq_r)
);

// File: alstat_codec_model.sv
module alstat_codec_model
    import alstat_pkg::*;
(
    output logic link_clk,
    output logic link_rst,
    output logic slot12_valid,
    output alstat_slot_t slot12_low,
    output logic [1:0] codec_ready_in,
    output logic [1:0] resume_det
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [1:0] ready_r = 2'h0;

    ////////////////////////////////////////
    // Bit clock runs only inside frames and link reset, 6 ns period
    task tick(input int n);
        repeat (n)
        begin
            #3 link_clk = 1'b1;
            #3 link_clk = 1'b0;
        end
    endtask : tick

    // Link reset needs the clock running, so it ticks meanwhile
    task do_reset;
        link_clk = 1'b0;
        link_rst = 1'b1;
        slot12_valid = 1'b0;
        slot12_low = 4'h0;
        codec_ready_in = 2'h0;
        resume_det = 2'h0;
        tick(3);
        link_rst = 1'b0;
        tick(1);
    endtask : do_reset

    // One slot 12; trailing idle keeps frames over six core cycles apart
    task frame(input alstat_slot_t s, input logic [1:0] rdy, input logic [1:0] res);
        ready_r = ready_r | rdy;
        codec_ready_in = ready_r;
        slot12_low = s;
        slot12_valid = 1'b1;
        resume_det = res;
        tick(1);
        slot12_valid = 1'b0;
        resume_det = 2'h0;
        slot12_low = ~s; // Stale slot bits must not be trusted
        tick(5);
    endtask : frame
endmodule : alstat_codec_model

// File: tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import alstat_pkg::*;

    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic suspend_rst = 1'b1;
    alstat_io_req_t io_req = '0;
    logic read_timeout = 1'b0;
    alstat_chan_irq_t chan_irq = '0;
    logic gpio_change_irq_enable = 1'b0;
    logic [1:0] resume_irq_enable = 2'h0;
    wire [31:0] io_rdata_r;
    wire io_ack_r;
    wire gpio_change_irq_r;
    wire [1:0] resume_irq_r;
    wire link_clk;
    wire link_rst;
    wire slot12_valid;
    wire alstat_slot_t slot12_low;
    wire [1:0] codec_ready_in;
    wire [1:0] resume_det;
    int err_total = 0;
    int samples_checked = 0;
    logic [31:0] rdata;

    // Core clock, 200 MHz
    always #2.5 core_clk = ~core_clk;

    alstat_top DUT (.core_clk(core_clk), .sys_rst(sys_rst), .suspend_rst(suspend_rst),
        .io_req(io_req), .io_rdata_r(io_rdata_r), .io_ack_r(io_ack_r),
        .read_timeout(read_timeout), .chan_irq(chan_irq),
        .gpio_change_irq_enable(gpio_change_irq_enable),
        .resume_irq_enable(resume_irq_enable), .gpio_change_irq_r(gpio_change_irq_r),
        .resume_irq_r(resume_irq_r), .link_clk(link_clk), .link_rst(link_rst),
        .slot12_valid(slot12_valid), .slot12_low(slot12_low),
        .codec_ready_in(codec_ready_in), .resume_det(resume_det));

    alstat_codec_model u_codec (.link_clk(link_clk), .link_rst(link_rst),
        .slot12_valid(slot12_valid), .slot12_low(slot12_low),
        .codec_ready_in(codec_ready_in), .resume_det(resume_det));

    ////////////////////////////////////////
    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    task step;
        @(posedge core_clk);
        #1;
    endtask : step

    task check32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask : check32

    // Request is a one-cycle pulse; the ack lands right after the taking edge
    task bus(input logic rd, input logic wr, input logic [7:0] addr, input logic [3:0] be,
        input logic [31:0] wdata);
        int n;
        step;
        io_req = '{rd: rd, wr: wr, addr: addr, be: be, wdata: wdata};
        step;
        io_req = '0;
        n = 0;
        while (io_ack_r !== 1'b1 && n < 4)
        begin
            step;
            n++;
        end
        if (io_ack_r !== 1'b1)
        begin
            err_total++;
            give_verdict;
        end
        else
        begin
            rdata = io_rdata_r;
        end
    endtask : bus

    task rd32(input logic [7:0] addr, input logic [31:0] exp);
        bus(1'b1, 1'b0, addr, 4'hf, 32'h0);
        check32(rdata, exp);
    endtask : rd32

    task wr32(input logic [31:0] d, input logic [3:0] be);
        bus(1'b0, 1'b1, 8'h30, be, d);
    endtask : wr32

    ////////////////////////////////////////
    task t_regs;
        rd32(8'h30, 32'h0030_0000);
        wr32(32'hffff_ffff, 4'hf);
        rd32(8'h30, 32'h0033_0000);
        wr32(32'h0, 4'h3);
        rd32(8'h30, 32'h0033_0000);
        rd32(8'h34, 32'h0);
        bus(1'b1, 1'b0, 8'h30, 4'h3, 32'h0);
        check32(rdata, 32'h0);
        wr32(32'h0, 4'hf);
        rd32(8'h30, 32'h0030_0000);
        $display("t_regs done");
    endtask : t_regs

    task t_chan;
        logic [4:0] c;
        for (int i = 0; i < 5; i++)
        begin
            c = 5'h1 << i;
            chan_irq = c;
            rd32(8'h30, {24'h003000, c[4:2], 2'b00, c[1:0], 1'b0});
        end
        chan_irq = '0;
        rd32(8'h30, 32'h0030_0000);
        $display("t_chan done");
    endtask : t_chan

    task t_timeout;
        step;
        read_timeout = 1'b1;
        step;
        read_timeout = 1'b0;
        rd32(8'h30, 32'h0030_8000);
        wr32(32'h0, 4'hf);
        rd32(8'h30, 32'h0030_8000);
        wr32(32'h0000_8000, 4'hf);
        rd32(8'h30, 32'h0030_0000);
        $display("t_timeout done");
    endtask : t_timeout

    // Crossing from the gated link clock; gpio enable removed for the second frame
    task t_link;
        gpio_change_irq_enable = 1'b1;
        resume_irq_enable = 2'b01;
        u_codec.frame(4'b1011, 2'b11, 2'b11);
        repeat (8) step;
        rd32(8'h30, 32'h0030_5f01);
        check32({31'h0, gpio_change_irq_r}, 32'h1);
        check32({30'h0, resume_irq_r}, 32'h1);
        wr32(32'h0000_0c01, 4'hf);
        rd32(8'h30, 32'h0030_5300);
        repeat (2) step;
        check32({31'h0, gpio_change_irq_r}, 32'h0);
        check32({30'h0, resume_irq_r}, 32'h0);
        gpio_change_irq_enable = 1'b0;
        u_codec.frame(4'b0101, 2'b00, 2'b00);
        repeat (8) step;
        rd32(8'h30, 32'h0030_2301);
        check32({31'h0, gpio_change_irq_r}, 32'h0);
        $display("t_link done");
    endtask : t_link

    // Core-only reset with the link left running: semaphores and ready survive,
    // flags and mirror clear, and odd resume toggles must not raise false events
    task t_reset;
        wr32(32'h0003_0000, 4'hf);
        step;
        sys_rst = 1'b1;
        repeat (3) step;
        sys_rst = 1'b0;
        repeat (4) step;
        rd32(8'h30, 32'h0033_0300);
        $display("t_reset done");
    endtask : t_reset

    ////////////////////////////////////////
    // Both wells and the link reset together so the toggles agree
    initial
    begin
        fork
            u_codec.do_reset;
            repeat (10) @(posedge core_clk);
        join
        #1;
        sys_rst = 1'b0;
        suspend_rst = 1'b0;
        t_regs;
        t_chan;
        t_timeout;
        t_link;
        t_reset;
        give_verdict;
    end
endmodule : tb_top
